/* File: dcfm_assertions.sv */
/*
  Checker on the port flags and mailbox flags of dcfm_top.
  Assumes it is bound into dcfm_top and sees only its ports.
*/
`timescale 1ns/1ps
module dcfm_assertions (
  input wire clk,
  input wire rst_b,
  input wire portAClockEn,
  input wire portASelectN,
  input wire portADirection,
  input wire portAStrobe,
  input wire portAMailSelect,
  input wire portBClockEn,
  input wire portBSelectN,
  input wire portBDirection,
  input wire portBStrobe,
  input wire portBMailSelect,
  input wire emptyReadyFlag,
  input wire nearEmptyFlag,
  input wire fullReadyFlag,
  input wire nearFullFlag,
  input wire mailOneFlag,
  input wire mailTwoFlag
);
  // ****************
  // Mail events and flag checks.
  // ****************
  wire aMail = portAClockEn && !portASelectN && portAStrobe && portAMailSelect;
  wire bMail = portBClockEn && !portBSelectN && portBStrobe && portBMailSelect;
  wire aMailWr = aMail && portADirection;
  wire bMailRd = bMail && portBDirection;
  wire bMailWr = bMail && !portBDirection;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  chk_a_flag_domain: assert property (!portAClockEn |=>
    $stable(fullReadyFlag) && $stable(nearFullFlag)) else $error("A flag moved off A edge");
  chk_b_flag_domain: assert property (!portBClockEn |=>
    $stable(emptyReadyFlag) && $stable(nearEmptyFlag)) else $error("B flag moved off B edge");
  chk_full_near: assert property (!fullReadyFlag |-> !nearFullFlag)
    else $error("full without near full");
  chk_mail_one_low: assert property (aMailWr |=> !mailOneFlag)
    else $error("mail one flag not low after write");
  chk_mail_one_high: assert property (bMailRd && !aMailWr |=> mailOneFlag)
    else $error("mail one flag not high after read");
  chk_mail_one_hold: assert property (!mailOneFlag && !bMailRd |=> !mailOneFlag)
    else $error("mail one flag rose without read");
  chk_mail_two_low: assert property (bMailWr |=> !mailTwoFlag)
    else $error("mail two flag not low after write");
  chk_mail_two_high: assert property (aMail && !portADirection && !bMailWr |=>
    mailTwoFlag) else $error("mail two flag not high after read");
endmodule // dcfm_assertions

/* File: dcfm_map.vh */
/*
  Address map, field positions, reset values and encodings of the dual clock
  FIFO flag and mailbox block. Assumes inclusion by the design file and the bench.
*/
`ifndef DCFM_MAP_VH
`define DCFM_MAP_VH

// ****************************************************************
// Register byte addresses.
// ****************************************************************
`define DCFM_ADDR_CTRL 12'h000
`define DCFM_ADDR_NEAR_EMPTY_OFS 12'h004
`define DCFM_ADDR_NEAR_FULL_OFS 12'h008
`define DCFM_ADDR_STATUS 12'h00c
`define DCFM_ADDR_MAIL_A_TO_B 12'h010
`define DCFM_ADDR_MAIL_B_TO_A 12'h014

// ****************************************************************
// Field positions.
// ****************************************************************
`define DCFM_CTRL_FALL_THROUGH_MODE_BIT 0
`define DCFM_CTRL_SIZE_LSB 1
`define DCFM_CTRL_SIZE_MSB 2
`define DCFM_STAT_EMPTY_READY_BIT 0
`define DCFM_STAT_NEAR_EMPTY_BIT 1
`define DCFM_STAT_FULL_READY_BIT 2
`define DCFM_STAT_NEAR_FULL_BIT 3
`define DCFM_STAT_MAIL_ONE_BIT 4
`define DCFM_STAT_MAIL_TWO_BIT 5

// ****************************************************************
// Port B bus size encodings.
// ****************************************************************
`define DCFM_SIZE_LONG 2'h0
`define DCFM_SIZE_WORD 2'h1
`define DCFM_SIZE_BYTE 2'h2

// ****************************************************************
// Reset values.
// ****************************************************************
`define DCFM_RST_CTRL 3'h0
`define DCFM_RST_OFS 8

`endif

/* File: dcfm_port_clocks.sv */
/*
  Far-side port clocks: free-running port A and port B edges as enable pulses.
  Assumes the bench clock clk and reset rst_b.
*/
`timescale 1ns/1ps
module dcfm_port_clocks #(
  parameter A_DIV = 2,
  parameter B_DIV = 3
) (
  input wire clk,
  input wire rst_b,
  output reg portAClockEn,
  output reg portBClockEn
);
  // ****************
  // Divided edges; the A and B edges coincide now and then.
  // ****************
  integer aCnt_r = 0;
  integer bCnt_r = 0;
  always @(posedge clk) begin
    aCnt_r <= (aCnt_r + 1) % A_DIV;
    bCnt_r <= (bCnt_r + 1) % B_DIV;
    portAClockEn <= (aCnt_r == 0);
    portBClockEn <= (bCnt_r == 0);
  end
endmodule // dcfm_port_clocks

/* File: dcfm_top.v */
/*
  Flag, pointer, memory and mailbox logic of a one-way 36-bit FIFO with an
  AHB-Lite register slave. Assumes one clock clk; each port clock edge arrives
  as a one-cycle enable pulse synchronous to clk, and the offsets are kept
  steady while data is in the FIFO.
*/
`timescale 1ns/1ps
`include "dcfm_map.vh"

module dcfm_top #(
  parameter DEPTH = 256,
  parameter AW = 8,
  parameter DW = 36
) (
  input wire clk,
  input wire rst_b,
  input wire portAClockEn,
  input wire portASelectN,
  input wire portADirection,
  input wire portAStrobe,
  input wire portAMailSelect,
  input wire [DW-1:0] portADataIn,
  output reg [DW-1:0] portADataOut,
  output reg portADataOeN,
  input wire portBClockEn,
  input wire portBSelectN,
  input wire portBDirection,
  input wire portBStrobe,
  input wire portBMailSelect,
  input wire [DW-1:0] portBDataIn,
  output reg [DW-1:0] portBDataOut,
  output reg portBDataOeN,
  output reg emptyReadyFlag,
  output reg nearEmptyFlag,
  output reg fullReadyFlag,
  output reg nearFullFlag,
  output reg mailOneFlag,
  output reg mailTwoFlag,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp
);

  // ****************************************************************
  // Helper functions.
  // ****************************************************************
  // Words held in memory between a write and a read pointer.
  function [AW:0] wordCount;
    input [AW:0] wp;
    input [AW:0] rp;
    begin
      wordCount = wp - rp;
    end
  endfunction

  // Mailbox lanes that the port B bus size lets through.
  function [DW-1:0] sizeMask;
    input [1:0] size;
    begin
      case (size)
        `DCFM_SIZE_WORD: sizeMask = {{(DW-18){1'b0}}, {18{1'b1}}};
        `DCFM_SIZE_BYTE: sizeMask = {{(DW-9){1'b0}}, {9{1'b1}}};
        default: sizeMask = {DW{1'b1}};
      endcase
    end
  endfunction

  localparam [AW:0] DEPTH_W = DEPTH;
  localparam [AW-1:0] RST_OFS_W = `DCFM_RST_OFS;

  // ****************************************************************
  // Configuration registers.
  // ****************************************************************
  reg fallThroughModeR;
  reg [1:0] busSizeR;
  reg [AW-1:0] nearEmptyOfsR;
  reg [AW-1:0] nearFullOfsR;
  reg [DW-1:0] mailboxAToB;
  reg [DW-1:0] mailboxBToA;

  // ****************************************************************
  // Memory and pointers.
  // ****************************************************************
  reg [DW-1:0] mem [0:DEPTH-1];
  reg [DW-1:0] outWordR;
  reg [AW:0] wrPtrR;
  reg [AW:0] rdPtrR;
  reg [AW:0] rdPtrSyncA1R;
  reg [AW:0] wrPtrSyncB1R;
  reg [AW:0] wrPtrSyncB2R;

  // ****************************************************************
  // Port decode.
  // ****************************************************************
  wire portAWrSel = portAClockEn & ~portASelectN & portADirection & portAStrobe;
  wire portARdSel = portAClockEn & ~portASelectN & ~portADirection & portAStrobe;
  wire portBRdSel = portBClockEn & ~portBSelectN & portBDirection & portBStrobe;
  wire portBWrSel = portBClockEn & ~portBSelectN & ~portBDirection & portBStrobe;
  wire fifoWrite = portAWrSel & ~portAMailSelect & fullReadyFlag;
  wire fifoRead = portBRdSel & ~portBMailSelect & emptyReadyFlag;
  wire mailOneWrite = portAWrSel & portAMailSelect & mailOneFlag;
  wire mailOneRead = portBRdSel & portBMailSelect;
  wire mailTwoWrite = portBWrSel & portBMailSelect & mailTwoFlag;
  wire mailTwoRead = portARdSel & portAMailSelect;

  // ****************************************************************
  // Port A domain: write pointer and full side flags.
  // ****************************************************************
  wire [AW:0] wrPtrNxt = wrPtrR + {{AW{1'b0}}, fifoWrite};
  // The read pointer seen here is one A edge old, so a read is felt at the
  // second A edge after it, and so is a read on the same edge as an A edge.
  wire [AW:0] fullCount = wordCount(wrPtrNxt, rdPtrSyncA1R);
  wire [AW:0] nearFullLimit = DEPTH_W - {1'b0, nearFullOfsR};

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wrPtrR <= {(AW+1){1'b0}};
      rdPtrSyncA1R <= {(AW+1){1'b0}};
      fullReadyFlag <= 1'b0;
      nearFullFlag <= 1'b0;
    end else if (portAClockEn) begin
      if (fifoWrite) begin
        mem[wrPtrR[AW-1:0]] <= portADataIn;
      end
      wrPtrR <= wrPtrNxt;
      rdPtrSyncA1R <= rdPtrR;
      fullReadyFlag <= (fullCount != DEPTH_W);
      nearFullFlag <= (fullCount < nearFullLimit);
    end
  end

  // ****************************************************************
  // Port B domain: read pointer, output register and empty side flags.
  // ****************************************************************
  // Stage one gives the second-edge view, stage two the third-edge view.
  wire [AW:0] memCount1 = wordCount(wrPtrSyncB1R, rdPtrR);
  wire [AW:0] memCount2 = wordCount(wrPtrSyncB2R, rdPtrR);
  reg loadOut;
  reg outReadyNxt;

  always @* begin
    loadOut = 1'b0;
    outReadyNxt = emptyReadyFlag;
    if (fallThroughModeR) begin
      if (!emptyReadyFlag || fifoRead) begin
        loadOut = (memCount2 != {(AW+1){1'b0}});
        outReadyNxt = loadOut;
      end
    end else begin
      loadOut = fifoRead;
    end
  end

  wire [AW:0] rdPtrNxt = rdPtrR + {{AW{1'b0}}, loadOut};
  wire [AW:0] emptyCount = wordCount(wrPtrSyncB1R, rdPtrNxt);
  wire [AW:0] nearEmptyLevel = {1'b0, nearEmptyOfsR};

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdPtrR <= {(AW+1){1'b0}};
      wrPtrSyncB1R <= {(AW+1){1'b0}};
      wrPtrSyncB2R <= {(AW+1){1'b0}};
      outWordR <= {DW{1'b0}};
      emptyReadyFlag <= 1'b0;
      nearEmptyFlag <= 1'b0;
    end else if (portBClockEn) begin
      wrPtrSyncB1R <= wrPtrR;
      wrPtrSyncB2R <= wrPtrSyncB1R;
      if (loadOut) begin
        outWordR <= mem[rdPtrR[AW-1:0]];
      end
      rdPtrR <= rdPtrNxt;
      if (fallThroughModeR) begin
        emptyReadyFlag <= outReadyNxt;
      end else begin
        emptyReadyFlag <= (emptyCount != {(AW+1){1'b0}});
      end
      nearEmptyFlag <= (emptyCount > nearEmptyLevel);
    end
  end

  // ****************************************************************
  // Mailboxes.
  // ****************************************************************
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mailboxAToB <= {DW{1'b0}};
      mailboxBToA <= {DW{1'b0}};
      mailOneFlag <= 1'b1;
      mailTwoFlag <= 1'b1;
    end else begin
      if (mailOneWrite) begin
        mailboxAToB <= portADataIn & sizeMask(busSizeR);
        mailOneFlag <= 1'b0;
      end else if (mailOneRead) begin
        mailOneFlag <= 1'b1;
      end
      if (mailTwoWrite) begin
        mailboxBToA <= portBDataIn & sizeMask(busSizeR);
        mailTwoFlag <= 1'b0;
      end else if (mailTwoRead) begin
        mailTwoFlag <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Data pin drivers.
  // ****************************************************************
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      portADataOut <= {DW{1'b0}};
      portADataOeN <= 1'b1;
      portBDataOut <= {DW{1'b0}};
      portBDataOeN <= 1'b1;
    end else begin
      portADataOut <= mailboxBToA;
      portADataOeN <= ~(~portASelectN & ~portADirection);
      portBDataOut <= portBMailSelect ? mailboxAToB : outWordR;
      portBDataOeN <= ~(~portBSelectN & portBDirection);
    end
  end

  // ****************************************************************
  // AHB-Lite register slave.
  // ****************************************************************
  reg dataPhaseWrR;
  reg [11:0] dataPhaseAddrR;
  wire addrPhase = hsel & htrans[1] & hready;
  reg [31:0] readValue;

  always @* begin
    case (haddr[11:0])
      `DCFM_ADDR_CTRL: readValue = {29'h0, busSizeR, fallThroughModeR};
      `DCFM_ADDR_NEAR_EMPTY_OFS: readValue = {{(32-AW){1'b0}}, nearEmptyOfsR};
      `DCFM_ADDR_NEAR_FULL_OFS: readValue = {{(32-AW){1'b0}}, nearFullOfsR};
      `DCFM_ADDR_STATUS: readValue = {26'h0, mailTwoFlag, mailOneFlag,
        nearFullFlag, fullReadyFlag, nearEmptyFlag, emptyReadyFlag};
      `DCFM_ADDR_MAIL_A_TO_B: readValue = mailboxAToB[31:0];
      `DCFM_ADDR_MAIL_B_TO_A: readValue = mailboxBToA[31:0];
      default: readValue = 32'h0;
    endcase
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dataPhaseWrR <= 1'b0;
      dataPhaseAddrR <= 12'h000;
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      fallThroughModeR <= 1'b0;
      busSizeR <= `DCFM_SIZE_LONG;
      nearEmptyOfsR <= RST_OFS_W;
      nearFullOfsR <= RST_OFS_W;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      dataPhaseWrR <= addrPhase & hwrite;
      dataPhaseAddrR <= haddr[11:0];
      if (addrPhase & ~hwrite) begin
        hrdata <= readValue;
      end
      if (dataPhaseWrR) begin
        case (dataPhaseAddrR)
          `DCFM_ADDR_CTRL: begin
            fallThroughModeR <= hwdata[`DCFM_CTRL_FALL_THROUGH_MODE_BIT];
            busSizeR <= hwdata[`DCFM_CTRL_SIZE_MSB:`DCFM_CTRL_SIZE_LSB];
          end
          `DCFM_ADDR_NEAR_EMPTY_OFS: nearEmptyOfsR <= hwdata[AW-1:0];
          `DCFM_ADDR_NEAR_FULL_OFS: nearFullOfsR <= hwdata[AW-1:0];
          default: begin
          end
        endcase
      end
    end
  end

endmodule // dcfm_top

/* File: tb_top.sv */
/*
  Self-checking bench of dcfm_top with the port clock model and the checker.
  Assumes the design header dcfm_map.vh on the include path.
*/
`timescale 1ns/1ps
`include "dcfm_map.vh"
module tb_top;
  // ****************
  // Signals, instances and tasks.
  // ****************
  localparam DEPTH = 16;
  localparam X = 2;
  localparam Y = 3;
  reg clk = 1'b0;
  reg rst_b = 1'b0;
  reg portASelectN = 1'b1, portADirection = 1'b0, portAStrobe = 1'b0, portAMailSelect = 1'b0;
  reg portBSelectN = 1'b1, portBDirection = 1'b0, portBStrobe = 1'b0, portBMailSelect = 1'b0;
  reg [35:0] portADataIn = 36'h0, portBDataIn = 36'h0;
  reg hsel = 1'b0, hwrite = 1'b0;
  reg [1:0] htrans = 2'h0;
  reg [2:0] hsize = 3'h2;
  reg [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
  wire portAClockEn, portBClockEn, portADataOeN, portBDataOeN, hreadyout, hresp;
  wire emptyReadyFlag, nearEmptyFlag, fullReadyFlag, nearFullFlag, mailOneFlag, mailTwoFlag;
  wire [35:0] portADataOut, portBDataOut;
  wire [31:0] hrdata;
  integer failCount = 0, numChecks = 0, cycles = 0, n, i;
  dcfm_port_clocks i_clks (.clk(clk), .rst_b(rst_b), .portAClockEn(portAClockEn),
    .portBClockEn(portBClockEn));
  dcfm_top #(.DEPTH(DEPTH), .AW(4)) i_dut (.clk(clk), .rst_b(rst_b),
    .portAClockEn(portAClockEn), .portASelectN(portASelectN), .portADirection(portADirection),
    .portAStrobe(portAStrobe), .portAMailSelect(portAMailSelect), .portADataIn(portADataIn),
    .portADataOut(portADataOut), .portADataOeN(portADataOeN), .portBClockEn(portBClockEn),
    .portBSelectN(portBSelectN), .portBDirection(portBDirection), .portBStrobe(portBStrobe),
    .portBMailSelect(portBMailSelect), .portBDataIn(portBDataIn), .portBDataOut(portBDataOut),
    .portBDataOeN(portBDataOeN), .emptyReadyFlag(emptyReadyFlag), .nearEmptyFlag(nearEmptyFlag),
    .fullReadyFlag(fullReadyFlag), .nearFullFlag(nearFullFlag), .mailOneFlag(mailOneFlag),
    .mailTwoFlag(mailTwoFlag), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp));
  task check(input [35:0] got, input [35:0] exp);
    begin
      numChecks = numChecks + 1;
      if (got !== exp) begin
        failCount = failCount + 1;
        $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task checkNum(input integer got, input integer exp);
    begin
      numChecks = numChecks + 1;
      if (got != exp) begin
        failCount = failCount + 1;
        $display("CHECK FAILED at %0t: %0d edges, expected %0d", $time, got, exp);
      end
    end
  endtask
  task ahb(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {20'h0, a};
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      rd = hrdata;
    end
  endtask
  task portA(input dir, input mail, input [35:0] d);
    begin
      @(posedge clk);
      portASelectN <= 1'b0;
      portADirection <= dir;
      portAStrobe <= 1'b1;
      portAMailSelect <= mail;
      portADataIn <= d;
      @(posedge clk);
      while (portAClockEn !== 1'b1) @(posedge clk);
      portAStrobe <= 1'b0;
      portASelectN <= 1'b1;
      portADataIn <= ~d;
    end
  endtask
  task portB(input dir, input mail, input [35:0] d);
    begin
      @(posedge clk);
      portBSelectN <= 1'b0;
      portBDirection <= dir;
      portBStrobe <= 1'b1;
      portBMailSelect <= mail;
      portBDataIn <= d;
      @(posedge clk);
      while (portBClockEn !== 1'b1) @(posedge clk);
      portBStrobe <= 1'b0;
      portBSelectN <= 1'b1;
      portBDataIn <= ~d;
    end
  endtask
  task edges(input b);
    integer t;
    begin
      n = 0;
      for (t = 0; t < 60; t = t + 1) begin
        @(posedge clk);
        if (b ? portBClockEn : portAClockEn) n = n + 1;
        #1;
        if ((b ? emptyReadyFlag : fullReadyFlag) === 1'b1) t = 60;
      end
    end
  endtask
  task settle;
    begin
      @(posedge clk);
      #1;
    end
  endtask
  task results;
    begin
      $display("Checks %0d, mismatches %0d", numChecks, failCount);
      if (failCount == 0 && numChecks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      failCount = failCount + 1;
      results;
    end
  end
  // ****************
  // Test sequence.
  // ****************
  initial begin
    repeat (5) @(posedge clk);
    check(fullReadyFlag, 0);
    rst_b <= 1'b1;
    edges(1'b0);
    check(fullReadyFlag, 1);
    ahb(1, `DCFM_ADDR_NEAR_EMPTY_OFS, X);
    ahb(1, `DCFM_ADDR_NEAR_FULL_OFS, Y);
    ahb(1, `DCFM_ADDR_CTRL, 0);
    ahb(0, `DCFM_ADDR_NEAR_EMPTY_OFS, 0);
    check(rd, X);
    ahb(0, 12'h100, 0);
    check(rd, 0);
    ahb(0, `DCFM_ADDR_STATUS, 0);
    check(rd, 32'h3c);
    check(hresp, 0);
    $display("Test registers done");
    portA(1, 0, 36'h0a5a5a5a5);
    edges(1'b1);
    checkNum(n, 2);
    check(nearEmptyFlag, 0);
    portB(1, 0, 0);
    settle;
    check(portBDataOut, 36'h0a5a5a5a5);
    check(portBDataOeN, 1);
    check(emptyReadyFlag, 0);
    portB(1, 0, 0);
    settle;
    check(portBDataOut, 36'h0a5a5a5a5);
    for (i = 1; i <= DEPTH; i = i + 1) begin
      portA(1, 0, 36'h100 + i);
      repeat (8) @(posedge clk);
      #1;
      if (i == X) check(nearEmptyFlag, 0);
      if (i == X + 1) check(nearEmptyFlag, 1);
      if (i == DEPTH - Y - 1) check(nearFullFlag, 1);
      if (i == DEPTH - Y) check(nearFullFlag, 0);
    end
    check(fullReadyFlag, 0);
    portA(1, 0, 36'h0bad);
    portB(1, 0, 0);
    edges(1'b0);
    checkNum(n, 2);
    for (i = 1; i <= DEPTH; i = i + 1) begin
      if (i > 1) portB(1, 0, 0);
      settle;
      check(portBDataOut, 36'h100 + i);
    end
    check(emptyReadyFlag, 0);
    $display("Test standard mode done");
    ahb(1, `DCFM_ADDR_CTRL, 1);
    portA(1, 0, 36'h0c3c3c3c3);
    edges(1'b1);
    checkNum(n, 3);
    check(nearEmptyFlag, 0);
    settle;
    check(portBDataOut, 36'h0c3c3c3c3);
    portB(1, 0, 0);
    settle;
    check(emptyReadyFlag, 0);
    $display("Test fall through done");
    ahb(1, `DCFM_ADDR_CTRL, {29'h0, `DCFM_SIZE_BYTE, 1'b0});
    portA(1, 1, 36'hfffffffff);
    settle;
    check(mailOneFlag, 0);
    portA(1, 1, 36'h0);
    ahb(0, `DCFM_ADDR_MAIL_A_TO_B, 0);
    check(rd, 32'h1ff);
    portB(1, 1, 0);
    settle;
    check(portBDataOut, 36'h1ff);
    check(mailOneFlag, 1);
    portB(0, 1, 36'h123456789);
    ahb(0, `DCFM_ADDR_MAIL_B_TO_A, 0);
    check(rd, 32'h189);
    check(mailTwoFlag, 0);
    portA(0, 1, 0);
    settle;
    check(portADataOut, 36'h189);
    check(mailTwoFlag, 1);
    $display("Test mailboxes done");
    results;
  end
endmodule // tb_top
bind dcfm_top dcfm_assertions i_chk (.clk(clk), .rst_b(rst_b), .portAClockEn(portAClockEn),
  .portASelectN(portASelectN), .portADirection(portADirection), .portAStrobe(portAStrobe),
  .portAMailSelect(portAMailSelect), .portBClockEn(portBClockEn), .portBSelectN(portBSelectN),
  .portBDirection(portBDirection), .portBStrobe(portBStrobe), .portBMailSelect(portBMailSelect),
  .emptyReadyFlag(emptyReadyFlag), .nearEmptyFlag(nearEmptyFlag), .fullReadyFlag(fullReadyFlag),
  .nearFullFlag(nearFullFlag), .mailOneFlag(mailOneFlag), .mailTwoFlag(mailTwoFlag));
